// File: design/move_ccr_ea_decode.v
// How it works
// RQ1 - General move destination must be data-alterable; address register, immediate, PC-relative rejected.
// RQ2 - Source modes 000 to 110 decode from 3-bit mode and register fields.
// RQ3 - Mode 111 register field picks absolute, immediate or PC-relative forms.
// RQ4 - Byte-size general move rejects address register direct source.
// RQ5 - Extended forms reuse mode 110, PC forms reuse 111 with register 011.
// RQ6 - Address move: size 11 sign-extends word to 32 bits, 10 is long.
// RQ7 - Address move accepts every source mode; 3-bit field picks address register.
// RQ8 - Flags read writes a word with flags low, zero above.
// RQ9 - Flags read needs data-alterable destination and leaves flags unchanged.
// RQ10 - Flags write uses low source byte; status upper byte unchanged.
// RQ11 - Flags write loads X,N,Z,V,C from source bits 4 to 0.
// RQ12 - Flags write accepts data modes including immediate and PC-relative, not address register direct.
// RQ13 - Moves into and out of the flags are word sized.
// RQ14 - Immediate AND, OR, XOR on the flags are byte sized.
// RQ15 - General move size: byte 01, word 11, long 10.
// RQ16 - General move sets N and Z, clears V and C, keeps X.
// RQ17 - Destination mode address register marks the address move, which never alters flags.
`timescale 1ns/1ps
`default_nettype none
`include "move_ccr_map.vh"

module move_ccr_ea_decode (
   input wire REF_CLK,
   input wire RST_N,
   input wire [7:0] AWADDR,
   input wire [2:0] AWPROT,
   input wire AWVALID,
   output wire AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output wire WREADY,
   output wire [1:0] BRESP,
   output wire BVALID,
   input wire BREADY,
   input wire [7:0] ARADDR,
   input wire [2:0] ARPROT,
   input wire ARVALID,
   output wire ARREADY,
   output wire [31:0] RDATA,
   output wire [1:0] RRESP,
   output wire RVALID,
   input wire RREADY
);

   ////////////////////////////////////////////////////////////////
   // Bus slave state
   reg aw_hold_reg;
   reg [7:0] awaddr_reg;
   reg w_hold_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [1:0] rresp_reg;
   reg [31:0] rdata_reg;

   // Block state
   reg [15:0] opcode_reg;
   reg [31:0] src_reg;
   reg [31:0] result_reg;
   reg [4:0] flags_reg;
   reg [7:0] sysbyte_reg;
   reg [4:0] status_reg;
   reg [31:0] areg_file [0:7];

   wire aw_take = AWVALID && AWREADY;
   wire w_take = WVALID && WREADY;
   wire aw_have = aw_hold_reg || aw_take;
   wire w_have = w_hold_reg || w_take;
   wire wr_fire = aw_have && w_have;
   wire [7:0] wr_addr = aw_hold_reg ? awaddr_reg : AWADDR;
   wire [31:0] wr_data = w_hold_reg ? wdata_reg : WDATA;
   wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : WSTRB;
   wire [7:0] wr_word = {wr_addr[7:2], 2'b00};
   wire [7:0] rd_word = {ARADDR[7:2], 2'b00};

   // Holding both channels until the response drains keeps one write in flight
   assign AWREADY = !aw_hold_reg && !bvalid_reg;
   assign WREADY = !w_hold_reg && !bvalid_reg;
   assign BVALID = bvalid_reg;
   assign BRESP = bresp_reg;
   assign ARREADY = !rvalid_reg;
   assign RVALID = rvalid_reg;
   assign RRESP = rresp_reg;
   assign RDATA = rdata_reg;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   wire wr_opcode = wr_fire && (wr_word == `OFF_OPCODE);
   wire wr_src = wr_fire && (wr_word == `OFF_SRC);
   wire wr_sysbyte = wr_fire && (wr_word == `OFF_SYSBYTE);
   wire exec_go = wr_fire && (wr_word == `OFF_CMD) && (wr_strb[0] == 1'b1);
   wire wr_mapped = (wr_word <= `OFF_SYSBYTE) || (wr_word[7:5] == `AREG_PAGE);
   wire [31:0] opcode_merged = merge({16'h0000, opcode_reg}, wr_data, wr_strb);

   ////////////////////////////////////////////////////////////////
   // Effective address decode
   wire [1:0] size_code = opcode_reg[`SIZE_HI:`SIZE_LO];
   wire [2:0] dst_reg = opcode_reg[`DREG_HI:`DREG_LO];
   wire [2:0] dst_mode = opcode_reg[`DMODE_HI:`DMODE_LO];
   wire [2:0] src_mode = opcode_reg[`SMODE_HI:`SMODE_LO];
   wire [2:0] src_regf = opcode_reg[`SREG_HI:`SREG_LO];
   wire src_valid;
   wire src_areg;
   wire src_imm;
   wire src_pcrel;
   wire dst_valid;
   wire dst_areg;
   wire dst_imm;
   wire dst_pcrel;

   ea_classify src_ea (
      .mode(src_mode),
      .regf(src_regf),
      .valid(src_valid),
      .is_areg(src_areg),
      .is_imm(src_imm),
      .is_pcrel(src_pcrel)
   );

   ea_classify dst_ea (
      .mode(dst_mode),
      .regf(dst_reg),
      .valid(dst_valid),
      .is_areg(dst_areg),
      .is_imm(dst_imm),
      .is_pcrel(dst_pcrel)
   );

   // The single-field instructions carry their operand in the source field
   wire src_data_alt = src_valid && !src_areg && !src_imm && !src_pcrel;
   wire src_data_mode = src_valid && !src_areg;
   wire dst_data_alt = dst_valid && !dst_areg && !dst_imm && !dst_pcrel;

   ////////////////////////////////////////////////////////////////
   // Execution
   wire [2:0] cmd_class = wr_data[2:0];
   wire addr_move = (dst_mode == `MODE_AREG); // RQ17
   wire size_ok = (size_code == `SIZE_BYTE) || (size_code == `SIZE_WORD) || (size_code == `SIZE_LONG); // RQ15

   reg illegal;
   reg [1:0] op_size;
   reg [31:0] sized;
   reg [31:0] result_next;
   reg result_we;
   reg [4:0] flags_next;
   reg [31:0] areg_value;
   reg areg_we;
   reg msb;

   always @* begin
      illegal = 1'b0;
      op_size = `SIZE_WORD;
      result_next = result_reg;
      result_we = 1'b0;
      flags_next = flags_reg;
      areg_value = src_reg;
      areg_we = 1'b0;
      case (size_code)
         `SIZE_BYTE: begin
            sized = {24'h00_0000, src_reg[7:0]};
            msb = src_reg[7];
         end
         `SIZE_WORD: begin
            sized = {16'h0000, src_reg[15:0]};
            msb = src_reg[15];
         end
         default: begin
            sized = src_reg;
            msb = src_reg[31];
         end
      endcase
      case (cmd_class)
         `CMD_MOVE: begin
            op_size = size_code;
            if (addr_move) begin
               illegal = !src_valid || !((size_code == `SIZE_WORD) || (size_code == `SIZE_LONG)); // RQ6 RQ7
               areg_we = 1'b1; // RQ7
               if (size_code == `SIZE_WORD) begin
                  areg_value = {{16{src_reg[15]}}, src_reg[15:0]}; // RQ6
               end
            end else begin
               illegal = !size_ok || !src_valid || !dst_data_alt; // RQ1 RQ15
               if ((size_code == `SIZE_BYTE) && src_areg) begin
                  illegal = 1'b1; // RQ4
               end
               result_we = 1'b1;
               result_next = sized;
               flags_next[`FLAG_N] = msb; // RQ16
               flags_next[`FLAG_Z] = (sized == `RST_WORD); // RQ16
               flags_next[`FLAG_V] = 1'b0; // RQ16
               flags_next[`FLAG_C] = 1'b0; // RQ16
            end
         end
         `CMD_FLAGS_READ: begin
            illegal = !src_data_alt; // RQ9
            result_we = 1'b1;
            result_next = {27'h000_0000, flags_reg}; // RQ8
            op_size = `SIZE_WORD; // RQ13
         end
         `CMD_FLAGS_WRITE: begin
            illegal = !src_data_mode; // RQ12
            flags_next = src_reg[`FLAG_X:`FLAG_C]; // RQ10 RQ11
            op_size = `SIZE_WORD; // RQ13
         end
         `CMD_AND_IMM: begin
            flags_next = flags_reg & src_reg[4:0];
            op_size = `SIZE_BYTE; // RQ14
         end
         `CMD_OR_IMM: begin
            flags_next = flags_reg | src_reg[4:0];
            op_size = `SIZE_BYTE; // RQ14
         end
         `CMD_XOR_IMM: begin
            flags_next = flags_reg ^ src_reg[4:0];
            op_size = `SIZE_BYTE; // RQ14
         end
         default: begin
            illegal = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Bus slave
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg <= `RST_ADDR;
         w_hold_reg <= 1'b0;
         wdata_reg <= `RST_WORD;
         wstrb_reg <= `RST_STRB;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= `RST_WORD;
      end else begin
         if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_DECERR;
         end else begin
            if (aw_take) begin
               aw_hold_reg <= 1'b1;
               awaddr_reg <= AWADDR;
            end
            if (w_take) begin
               w_hold_reg <= 1'b1;
               wdata_reg <= WDATA;
               wstrb_reg <= WSTRB;
            end
            if (bvalid_reg && BREADY) begin
               bvalid_reg <= 1'b0;
            end
         end
         if (ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `RESP_OKAY;
            case (rd_word)
               `OFF_OPCODE: rdata_reg <= {16'h0000, opcode_reg};
               `OFF_SRC: rdata_reg <= src_reg;
               `OFF_CMD: rdata_reg <= `RST_WORD;
               `OFF_STATUS: rdata_reg <= {27'h000_0000, status_reg};
               `OFF_RESULT: rdata_reg <= result_reg;
               `OFF_FLAGS: rdata_reg <= {27'h000_0000, flags_reg}; // RQ8
               `OFF_SYSBYTE: rdata_reg <= {24'h00_0000, sysbyte_reg};
               default: begin
                  if (rd_word[7:5] == `AREG_PAGE) begin
                     rdata_reg <= areg_file[rd_word[4:2]];
                  end else begin
                     rdata_reg <= `RST_WORD;
                     rresp_reg <= `RESP_DECERR;
                  end
               end
            endcase
         end else if (rvalid_reg && RREADY) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Software registers and execution results
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         opcode_reg <= `RST_OPCODE;
         src_reg <= `RST_WORD;
         result_reg <= `RST_WORD;
         flags_reg <= `RST_FLAGS;
         sysbyte_reg <= `RST_SYSBYTE;
         status_reg <= `RST_STATUS;
      end else begin
         if (wr_opcode) begin
            opcode_reg <= opcode_merged[15:0];
         end
         if (wr_src) begin
            src_reg <= merge(src_reg, wr_data, wr_strb);
         end
         // Flag writes never touch this byte
         if (wr_sysbyte && wr_strb[0]) begin
            sysbyte_reg <= wr_data[7:0]; // RQ10
         end
         if (exec_go) begin
            status_reg[`ST_ILLEGAL] <= illegal;
            status_reg[`ST_AMOVE] <= (cmd_class == `CMD_MOVE) && addr_move;
            status_reg[`ST_SIZE_HI:`ST_SIZE_LO] <= op_size;
            status_reg[`ST_DONE] <= 1'b1;
            // A rejected operation leaves every architectural value as it was
            if (!illegal) begin
               flags_reg <= flags_next; // RQ9 RQ16 RQ17
               if (result_we) begin
                  result_reg <= result_next;
               end
            end
         end
      end
   end

   // Address registers, written only by a legal address move
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : areg_slot
         always @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
               areg_file[g] <= `RST_WORD;
            end else if (exec_go && areg_we && !illegal && (dst_reg == g)) begin
               areg_file[g] <= areg_value; // RQ6 RQ7
            end
         end
      end
   endgenerate

endmodule // move_ccr_ea_decode
`default_nettype wire

// File: include/move_ccr_map.vh
`ifndef MOVE_CCR_MAP_VH
`define MOVE_CCR_MAP_VH

// Register byte offsets
`define OFF_OPCODE 8'h00
`define OFF_SRC 8'h04
`define OFF_CMD 8'h08
`define OFF_STATUS 8'h0C
`define OFF_RESULT 8'h10
`define OFF_FLAGS 8'h14
`define OFF_SYSBYTE 8'h18
`define OFF_AREG 8'h20
// Address bits 7:5 of the address register window
`define AREG_PAGE 3'h1

// Operation word fields
`define SIZE_HI 13
`define SIZE_LO 12
`define DREG_HI 11
`define DREG_LO 9
`define DMODE_HI 8
`define DMODE_LO 6
`define SMODE_HI 5
`define SMODE_LO 3
`define SREG_HI 2
`define SREG_LO 0

// Flag bit positions
`define FLAG_X 4
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0

// Status bit positions
`define ST_ILLEGAL 0
`define ST_AMOVE 1
`define ST_SIZE_LO 2
`define ST_SIZE_HI 3
`define ST_DONE 4

// Addressing mode codes
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`define MODE_DISP16 3'h5
`define MODE_INDEX 3'h6
`define MODE_EXT 3'h7
`define EXT_ABS_SHORT 3'h0
`define EXT_ABS_LONG 3'h1
`define EXT_PC_DISP 3'h2
`define EXT_PC_INDEX 3'h3
`define EXT_IMM 3'h4

// Size codes
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h3
`define SIZE_LONG 2'h2

// Command classes
`define CMD_MOVE 3'h0
`define CMD_FLAGS_READ 3'h1
`define CMD_FLAGS_WRITE 3'h2
`define CMD_AND_IMM 3'h3
`define CMD_OR_IMM 3'h4
`define CMD_XOR_IMM 3'h5

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_OPCODE 16'h0000
`define RST_FLAGS 5'h00
`define RST_SYSBYTE 8'h00
`define RST_STATUS 5'h00
`define RST_ADDR 8'h00
`define RST_STRB 4'h0

`endif

// File: design/ea_classify.v
`timescale 1ns/1ps
`default_nettype none
`include "move_ccr_map.vh"

module ea_classify (
   input wire [2:0] mode,
   input wire [2:0] regf,
   output reg valid,
   output reg is_areg,
   output reg is_imm,
   output reg is_pcrel
);

   always @* begin
      valid = 1'b1;
      is_areg = 1'b0;
      is_imm = 1'b0;
      is_pcrel = 1'b0;
      case (mode)
         `MODE_AREG: begin
            is_areg = 1'b1; // RQ2
         end
         // Extended base-displacement forms share the indexed code
         `MODE_INDEX: begin
            valid = 1'b1; // RQ5
         end
         `MODE_EXT: begin
            case (regf)
               `EXT_ABS_SHORT, `EXT_ABS_LONG: begin
                  valid = 1'b1; // RQ3
               end
               `EXT_IMM: begin
                  is_imm = 1'b1; // RQ3
               end
               `EXT_PC_DISP, `EXT_PC_INDEX: begin
                  is_pcrel = 1'b1; // RQ3
               end
               default: begin
                  valid = 1'b0;
               end
            endcase
         end
         default: begin
            valid = 1'b1; // RQ2
         end
      endcase
   end

endmodule // ea_classify
`default_nettype wire

// File: test/move_ccr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module move_ccr_sva (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic RREADY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic flags_rd_reg;
   ////////////////////////////////////////
   // Remembers whether the read in flight targets the flag word
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) flags_rd_reg <= 1'b0;
      else if (ARVALID && ARREADY) flags_rd_reg <= (ARADDR[7:2] == 6'h05);
   end
   a_flags_upper_zero: assert property (RVALID && flags_rd_reg |-> RDATA[31:5] == 27'h0)
      else $error("flag word has bits set above the flags");
   a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
      else $error("write response missing");
   a_write_refused: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write accepted while response pending");
   a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped early");
   a_bvalid_drop: assert property (BVALID && BREADY |=> !BVALID)
      else $error("write response repeated");
   a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
      else $error("read answer missing");
   a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data changed while stalled");
   a_rvalid_drop: assert property (RVALID && RREADY |=> !RVALID)
      else $error("read answer repeated");
   a_decerr_zero: assert property (RVALID && RRESP == 2'h3 |-> RDATA == 32'h0)
      else $error("unmapped read returned data");
   c_stalled_read: cover property (RVALID && !RREADY ##1 RVALID && RREADY);
   c_decerr: cover property (BVALID && BRESP == 2'h3);
   c_flags_read: cover property (RVALID && flags_rd_reg);
endmodule // move_ccr_sva
bind move_ccr_ea_decode move_ccr_sva u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
   .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
   .RREADY(RREADY));
`default_nettype wire

// File: test/axil_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module axil_master_model (
   input wire logic clk,
   input wire logic stall,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   ////////////////////////////////////////
   // A stalled master raises ready only after the answer shows up
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !stall;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !stall;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask
endmodule // axil_master_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, stall, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, sb;
   logic [31:0] wdata, rdata, res, rmask, s;
   logic [1:0] bresp, rresp, r;
   logic [65:0] q[$];
   logic [65:0] e;
   logic [15:0] lf, op;
   logic [4:0] flg;
   logic [31:0] ar [0:7];
   int err_total, checks;
   move_ccr_ea_decode dut (.REF_CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   axil_master_model u_m (.clk(clk), .stall(stall), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic ok(input logic [2:0] m, input logic [2:0] g);
      return m != 3'h7 || g <= 3'h4;
   endfunction
   function automatic logic dalt(input logic [2:0] m, input logic [2:0] g);
      return m != 3'h1 && (m != 3'h7 || g <= 3'h1);
   endfunction
   task automatic cmp(input logic [33:0] g, input logic [33:0] x);
      checks++;
      if (g !== x) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      q.push_back({(a == 8'h1C || a > 8'h3C) ? 2'h3 : 2'h0, x, m});
      u_m.rd(a);
   endtask
   // Mirrors each command on the bench's copy of the flags, result and address registers
   task automatic exec(input logic [15:0] o, input logic [31:0] d, input logic [2:0] c);
      logic [2:0] dr, dm, sm, sg;
      logic [1:0] sz, os;
      logic il, am;
      {sz, dr, dm, sm, sg} = o[13:0];
      os = c > 3'h2 ? 2'h1 : 2'h3;
      am = 1'b0;
      il = 1'b0;
      u_m.wr(8'h00, {16'h0000, o}, r);
      u_m.wr(8'h04, d, r);
      u_m.wr(8'h08, {29'h0000_0000, c}, r);
      case (c)
         3'h0: begin
            os = sz;
            am = dm == 3'h1;
            if (am) begin
               il = !sz[1] || !ok(sm, sg);
               if (!il) ar[dr] = sz[0] ? {{16{d[15]}}, d[15:0]} : d;
            end else begin
               il = sz == 2'h0 || !dalt(dm, dr) || !ok(sm, sg) || (sz == 2'h1 && sm == 3'h1);
               if (!il) begin
                  rmask = sz == 2'h1 ? 32'h0000_00FF : sz == 2'h3 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
                  res = d & rmask;
                  flg[3:0] = {|(res & ~(rmask >> 1)), res == 32'h0, 2'h0};
               end
            end
         end
         3'h1: begin
            il = !dalt(sm, sg);
            if (!il) {res, rmask} = {27'h0, flg, 32'hFFFF_FFFF};
         end
         3'h2: begin
            il = sm == 3'h1 || !ok(sm, sg);
            if (!il) flg = d[4:0];
         end
         3'h3: flg = flg & d[4:0];
         3'h4: flg = flg | d[4:0];
         3'h5: flg = flg ^ d[4:0];
         default: il = 1'b1;
      endcase
      chk(8'h0C, {27'h1, os, am, il}, il ? 32'h13 : 32'h1F);
      chk(8'h10, res, 32'hFFFF_FFFF);
      chk(8'h14, {27'h0, flg}, 32'hFFFF_FFFF);
      if (c == 3'h2) chk(8'h18, {24'h00_0000, sb}, 32'hFFFF_FFFF);
      if (am) chk(8'h20 + {3'h0, dr, 2'h0}, ar[dr], 32'hFFFF_FFFF);
   endtask
   task automatic print_verdict();
      $display("err_total=%0d checks=%0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   always @(posedge clk) begin
      if (rvalid && rready) begin
         e = q.pop_front();
         cmp({rresp, rdata & e[31:0]}, {e[65:64], e[63:32] & e[31:0]});
      end
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   initial begin
      {rst_n, stall, flg, res, rmask, sb, err_total, checks} = {2'h0, 5'h00, 32'h0, 32'hFFFF_FFFF, 8'hA5, 64'h0};
      lf = 16'h6D96;
      foreach (ar[i]) ar[i] = 32'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 8'h44; a += 4) chk(a[7:0], 32'h0, 32'hFFFF_FFFF);
      u_m.wr(8'h1C, 32'h1, r);
      cmp({r, 32'h0}, {2'h3, 32'h0});
      u_m.wr(8'h0C, 32'hFFFF_FFFF, r);
      cmp({r, 32'h0}, {2'h0, 32'h0});
      u_m.wr(8'h18, {24'h00_0000, sb}, r);
      for (int i = 0; i < 64; i++) begin
         lf = nx(lf);
         exec({10'h000, i[5:0]}, {lf, lf}, 3'h2);
         exec({10'h000, i[5:0]}, 32'h0, 3'h1);
         exec({4'h3, i[2:0], i[5:3], 6'h07}, {lf, 16'h8000}, 3'h0);
      end
      exec({4'h3, 3'h5, 3'h1, 6'h3C}, 32'h1234_8001, 3'h0);
      exec({4'h2, 3'h2, 3'h1, 6'h0B}, 32'h8765_4321, 3'h0);
      exec({4'h1, 3'h0, 3'h0, 6'h08}, 32'h0000_0080, 3'h0);
      exec({4'h1, 3'h0, 3'h0, 6'h3B}, 32'h0000_0080, 3'h0);
      for (int n = 0; n < 300; n++) begin
         lf = nx(lf);
         op = lf;
         lf = nx(lf);
         s = {lf, op};
         lf = nx(lf);
         stall = lf[3];
         exec(op, s, lf[2:0]);
      end
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
